// ===== bench/pmc_asserts.sv
// Port checks of the measurement period core
`timescale 1ns/1ps
module pmc_asserts #(
	parameter int HARM_PTS  = 9,
	parameter int FFT_LONG  = 40,
	parameter int FFT_SHORT = 20
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        harmWindow,
	input wire logic        fftWindow,
	input wire logic        resultValid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	int   harmCnt_q;
	int   fftCnt_q;
	logic fftLong_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			harmCnt_q <= 0;
			fftCnt_q  <= 0;
			fftLong_q <= 1'b0;
		end else begin
			harmCnt_q <= resultValid ? 0 : harmCnt_q + int'(harmWindow);
			fftCnt_q  <= resultValid ? 0 : fftCnt_q + int'(fftWindow);
			if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
				fftLong_q <= avs_writedata[11];
			end
		end
	end
	sequence s_ask; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_quiet; !resultValid [*8]; endsequence
	property p_answer; s_ask |=> !avs_waitrequest; endproperty
	property p_ans_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	property p_no_spur; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
	property p_unmap; s_ask ##0 (avs_read && avs_address >= 4'hc) |=> avs_readdata == 32'h0;
	endproperty
	property p_gap; resultValid |=> s_quiet; endproperty
	property p_harm; resultValid |-> harmCnt_q == HARM_PTS; endproperty
	property p_fft; resultValid |-> fftCnt_q == (fftLong_q ? FFT_LONG : FFT_SHORT); endproperty
	property p_nest; harmWindow |-> fftWindow; endproperty
	property p_eval; resultValid |-> !harmWindow && !fftWindow; endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	a_ans_one: assert property (p_ans_one) else $error("long answer");
	a_no_spur: assert property (p_no_spur) else $error("spurious answer");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_gap: assert property (p_gap) else $error("result pulse too close");
	a_harm: assert property (p_harm) else $error("harmonic window count");
	a_fft: assert property (p_fft) else $error("fft window count");
	a_nest: assert property (p_nest) else $error("harmonic outside fft window");
	a_eval: assert property (p_eval) else $error("window during evaluation");
endmodule : pmc_asserts
bind pmc_period_compute pmc_asserts #(.HARM_PTS(HARM_PTS), .FFT_LONG(FFT_LONG),
	.FFT_SHORT(FFT_SHORT)) pmc_asserts_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.harmWindow(harmWindow), .fftWindow(fftWindow), .resultValid(resultValid));

// ===== bench/pmc_front_end.sv
// Sampling front end model: square wave, 15 high and 15 low samples
`timescale 1ns/1ps
module pmc_front_end (
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   en,
	input  wire logic   slow,
	input  wire logic   smpReady,
	output logic        smpValid,
	output logic [15:0] smpVoltage,
	output logic [15:0] smpCurrent,
	output logic        smpExtClk
);
	int          n_q;
	logic        idle_q;
	logic        hi;
	assign hi         = (n_q % 30) < 15;
	assign smpValid   = en && !idle_q;
	// Lines show the inverse while no sample is offered
	assign smpVoltage = (hi ^ !smpValid) ? 16'h04b0 : 16'hfe70;
	assign smpCurrent = smpVoltage;
	assign smpExtClk  = hi ^ !smpValid;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_q    <= 0;
			idle_q <= 1'b0;
		end else begin
			idle_q <= slow && smpValid && smpReady;
			n_q    <= n_q + int'(smpValid && smpReady);
		end
	end
endmodule : pmc_front_end

// ===== bench/tb.sv
// Bench: configures the core over Avalon and checks the results of each interval
`timescale 1ns/1ps
module tb;
	logic        clk, rst_n, rdOp, wrOp, waitReq, smpValid, smpReady, extClk;
	logic        harmWin, fftWin, resValid, en, slow;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rd;
	logic [15:0] volt, curr;
	int          n_fail, check_count;
	pmc_period_compute #(.SAMPLE_HZ(2000), .HARM_PTS(9), .FFT_LONG(40), .FFT_SHORT(20))
		pmc_period_compute_i (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rdOp),
		.avs_write(wrOp), .avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(waitReq), .smpValid(smpValid), .smpReady(smpReady),
		.smpVoltage(volt), .smpCurrent(curr), .smpExtClk(extClk), .harmWindow(harmWin),
		.fftWindow(fftWin), .resultValid(resValid));
	pmc_front_end pmc_front_end_i (.clk(clk), .rst_n(rst_n), .en(en), .slow(slow),
		.smpReady(smpReady), .smpValid(smpValid), .smpVoltage(volt), .smpCurrent(curr),
		.smpExtClk(extClk));
	always #2.5 clk = ~clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Only the watchdog ends a wait for the slave
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		rdOp  <= !wr;
		wrOp  <= wr;
		do begin
			@(posedge clk);
		end while (waitReq !== 1'b0);
		rd = rdata;
		rdOp <= 1'b0;
		wrOp <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rdchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
		input string what);
		bus(1'b0, a, 32'h0);
		check(what, rd & m, e);
	endtask : rdchk
	task automatic wait_result();
		do begin
			@(posedge clk);
		end while (resValid !== 1'b1);
	endtask : wait_result
	initial begin
		#50000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		{clk, rst_n, rdOp, wrOp, en, slow, addr, wdata} = '0;
		{n_fail, check_count} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(4'h0, 32'hfff, 32'h0, "ctrl");
		rdchk(4'hc, 32'hffffffff, 32'h0, "unmapped");
		bus(1'b1, 4'h0, 32'h0000000e);
		en <= 1'b1;
		wait_result();
		// Next setting goes in early, before the window counts of the new interval pass it
		bus(1'b1, 4'h0, 32'h00000801);
		rdchk(4'h2, 32'hffffffff, 32'h190, "u dc");
		rdchk(4'h3, 32'hffffffff, 32'h320, "i rmn");
		rdchk(4'ha, 32'hffffffff, 32'h3c, "period rising");
		rdchk(4'h4, 32'hffffffff, 32'h4b0, "u max");
		rdchk(4'h5, 32'hffffffff, 32'hfffffe70, "u min");
		rdchk(4'h8, 32'hffffffff, 32'h300, "u crest");
		rdchk(4'h9, 32'hffffffff, 32'h180, "i crest");
		wait_result();
		bus(1'b1, 4'h0, 32'h00000082);
		slow <= 1'b1;
		rdchk(4'h2, 32'hffffffff, 32'h378, "u mn");
		rdchk(4'h3, 32'hffffffff, 32'h37e, "i rms");
		rdchk(4'ha, 32'hffffffff, 32'h5a, "period falling");
		rdchk(4'h1, 32'h3, 32'h2, "status falling");
		wait_result();
		// External sync, filter on, 50 ms
		bus(1'b1, 4'h0, 32'h0000042e);
		rdchk(4'ha, 32'hffffffff, 32'h1f4, "period whole");
		rdchk(4'h1, 32'h1, 32'h1, "status whole");
		rdchk(4'h2, 32'hffffffff, 32'h190, "u dc whole");
		wait_result();
		rdchk(4'h2, 32'hffffffff, 32'h190, "u dc ext");
		rdchk(4'h3, 32'hffffffff, 32'h372, "i rmn filtered");
		rdchk(4'ha, 32'hffffffff, 32'h5a, "period ext");
		rdchk(4'h6, 32'hffffffff, 32'h4b0, "i max");
		rdchk(4'h7, 32'hffffffff, 32'hfffffe70, "i min");
		report_and_stop();
	end
endmodule : tb

// ===== verilog/pmc_defines.svh
// Constants and register map of the power measurement period core
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
`define PMC_REG_CTRL     4'h0
`define PMC_REG_STATUS   4'h1
`define PMC_REG_U_VALUE  4'h2
`define PMC_REG_I_VALUE  4'h3
`define PMC_REG_U_MAXPK  4'h4
`define PMC_REG_U_MINPK  4'h5
`define PMC_REG_I_MAXPK  4'h6
`define PMC_REG_I_MINPK  4'h7
`define PMC_REG_U_CREST  4'h8
`define PMC_REG_I_CREST  4'h9
`define PMC_REG_PERIOD   4'ha
`define PMC_REG_COUNT    4'hb
`define PMC_CTRL_RESET   12'h000
`define PMC_CTRL_W       12
`define PMC_F_VMODE      1:0
`define PMC_F_IMODE      3:2
`define PMC_F_SYNC       5:4
`define PMC_F_RATE       9:6
`define PMC_B_FILT       10
`define PMC_B_FFTLONG    11
`define PMC_T_50MS       32'h32
`define PMC_T_100MS      32'h64
`define PMC_T_250MS      32'hfa
`define PMC_T_500MS      32'h1f4
`define PMC_T_1S         32'h3e8
`define PMC_T_2S         32'h7d0
`define PMC_T_5S         32'h1388
`define PMC_T_10S        32'h2710
`define PMC_T_20S        32'h4e20
`define PMC_MS_PER_S     32'h3e8
`define PMC_MAX_S        32'h14
`define PMC_SAMPLE_HZ    32'h30d40
`define PMC_HARM_POINTS  32'h2328
`define PMC_FFT_LONG     32'h30d40
`define PMC_FFT_SHORT    32'h4e20
`define PMC_CAL_COEF     16'h11c6
`define PMC_CAL_SHIFT    5'h0c
`define PMC_FILT_SHIFT   3'h3
`define PMC_CREST_FRAC   4'h8
`define PMC_FIFO_DEPTH   2
`endif

// ===== verilog/pmc_iter_unit.sv
// Shared shift-subtract unit for unsigned division and square root
`timescale 1ns/1ps
module pmc_iter_unit #(
	parameter int W = 56
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic         opSqrt,
	input  wire logic [W-1:0] opA,
	input  wire logic [W-1:0] opB,
	output logic              done,
	output logic [W-1:0]      result
);
	if (W < 4 || (W % 2) != 0) begin : g_bad
		$error("pmc_iter_unit needs an even W of at least 4");
	end
	logic [W-1:0]   a_q, b_q, q_q;
	logic [W+1:0]   rem_q, remN, trial;
	logic [$clog2(W+1)-1:0] cnt_q;
	logic           busy_q, sqrt_q, ge, done_q;

	always_comb begin
		if (sqrt_q) begin
			remN  = {rem_q[W-1:0], a_q[W-1:W-2]};
			trial = {q_q, 2'h1};
		end else begin
			remN  = {rem_q[W:0], a_q[W-1]};
			trial = {2'h0, b_q};
		end
		ge = (remN >= trial);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_q <= '0; b_q <= '0; q_q <= '0; rem_q <= '0;
			cnt_q <= '0; busy_q <= 1'b0; sqrt_q <= 1'b0; done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!busy_q && start) begin
				a_q    <= opA;
				b_q    <= opB;
				q_q    <= '0;
				rem_q  <= '0;
				sqrt_q <= opSqrt;
				cnt_q  <= opSqrt ? ($clog2(W+1))'(W / 2) : ($clog2(W+1))'(W);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				a_q   <= sqrt_q ? {a_q[W-3:0], 2'h0} : {a_q[W-2:0], 1'b0};
				rem_q <= ge ? remN - trial : remN;
				q_q   <= {q_q[W-2:0], ge};
				cnt_q <= cnt_q - ($clog2(W+1))'(1);
				if (cnt_q == ($clog2(W+1))'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end
	assign done   = done_q;
	assign result = q_q;
endmodule : pmc_iter_unit

// ===== verilog/pmc_period_compute.sv
// Measurement period, per-period formulas, peaks and window flags of one element
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_period_compute import pmc_pkg::*; #(
	parameter int SAMPLE_W  = 16,
	parameter int SAMPLE_HZ = `PMC_SAMPLE_HZ,
	parameter int HARM_PTS  = `PMC_HARM_POINTS,
	parameter int FFT_LONG  = `PMC_FFT_LONG,
	parameter int FFT_SHORT = `PMC_FFT_SHORT
) (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic [31:0]              avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                smpValid,
	output logic                     smpReady,
	input  wire logic [SAMPLE_W-1:0] smpVoltage,
	input  wire logic [SAMPLE_W-1:0] smpCurrent,
	input  wire logic                smpExtClk,
	output logic                     harmWindow,
	output logic                     fftWindow,
	output logic                     resultValid
);
	localparam int CNT_W = $clog2(SAMPLE_HZ * `PMC_MAX_S + 1);
	localparam int ACC_W = ((2 * SAMPLE_W + CNT_W + 2) / 2) * 2;
	if (SAMPLE_W < 4 || SAMPLE_W > 16 || SAMPLE_HZ < 20 || FFT_LONG >= (1 << CNT_W)
		|| FFT_SHORT >= (1 << CNT_W) || HARM_PTS >= (1 << CNT_W)) begin : g_bad
		$error("pmc_period_compute parameters out of range");
	end
	typedef logic signed [ACC_W-1:0] acc_t;

	////////////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic [CNT_W-1:0] rateSamples(input logic [3:0] code);
		logic [63:0] ms;
		logic [63:0] n;
		case (pmc_rate_t'(code))
			RATE_50MS:  ms = 64'(`PMC_T_50MS);
			RATE_100MS: ms = 64'(`PMC_T_100MS);
			RATE_250MS: ms = 64'(`PMC_T_250MS);
			RATE_500MS: ms = 64'(`PMC_T_500MS);
			RATE_1S:    ms = 64'(`PMC_T_1S);
			RATE_2S:    ms = 64'(`PMC_T_2S);
			RATE_5S:    ms = 64'(`PMC_T_5S);
			RATE_10S:   ms = 64'(`PMC_T_10S);
			RATE_20S:   ms = 64'(`PMC_T_20S);
			default:    ms = 64'(`PMC_T_50MS);
		endcase
		n = (64'(SAMPLE_HZ) * ms) / 64'(`PMC_MS_PER_S);
		rateSamples = (n == 64'h0) ? CNT_W'(1) : CNT_W'(n);
	endfunction : rateSamples

	function automatic logic zeroCrossRate(input logic [3:0] code);
		case (pmc_rate_t'(code))
			RATE_50MS, RATE_100MS, RATE_5S, RATE_10S, RATE_20S: zeroCrossRate = 1'b1;
			default: zeroCrossRate = 1'b0;
		endcase
	endfunction : zeroCrossRate

	// Accumulator slot of a formula: 0 squares, 1 magnitudes, 2 signed sum
	function automatic int accSlot(input logic [1:0] mode);
		case (pmc_mode_t'(mode))
			MODE_RMS:         accSlot = 0;
			MODE_MN, MODE_RMN: accSlot = 1;
			default:          accSlot = 2;
		endcase
	endfunction : accSlot

	function automatic logic [SAMPLE_W-1:0] absS(input logic signed [SAMPLE_W-1:0] x);
		absS = x[SAMPLE_W-1] ? SAMPLE_W'(-x) : SAMPLE_W'(x);
	endfunction : absS

	////////////////////////////////////////////////////////////////////////////////
	// Input buffer and sample decode
	logic [2*SAMPLE_W:0]        fData;
	logic                       fValid, coreReady, take, lastSample;
	logic signed [SAMPLE_W-1:0] samp [2];
	logic                       sExt;
	pmc_state_t                 state_q;
	logic [`PMC_CTRL_W-1:0]     ctrl_q;
	logic [CNT_W-1:0]           smpIdx_q, intLen;

	pmc_skid_buf #(.WIDTH(2 * SAMPLE_W + 1), .DEPTH(`PMC_FIFO_DEPTH)) u_buf (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (smpValid),
		.inReady  (smpReady),
		.inData   ({smpExtClk, smpCurrent, smpVoltage}),
		.outValid (fValid),
		.outReady (coreReady),
		.outData  (fData)
	);

	assign coreReady  = (state_q == ST_RUN);
	assign take       = fValid && coreReady;
	assign samp[0]    = fData[SAMPLE_W-1:0];
	assign samp[1]    = fData[2*SAMPLE_W-1:SAMPLE_W];
	assign sExt       = fData[2*SAMPLE_W];
	assign intLen     = rateSamples(ctrl_q[`PMC_F_RATE]);
	assign lastSample = take && (smpIdx_q >= intLen - CNT_W'(1));

	////////////////////////////////////////////////////////////////////////////////
	// Running sums over the update interval
	acc_t                     acc_q [6];
	acc_t                     contrib [6];
	logic signed [2*SAMPLE_W-1:0] sq [2];

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			sq[c]          = samp[c] * samp[c];
			contrib[c*3]   = ACC_W'(sq[c]);
			contrib[c*3+1] = acc_t'({1'b0, absS(samp[c])});
			contrib[c*3+2] = ACC_W'(samp[c]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < 6; k++)
				acc_q[k] <= '0;
			smpIdx_q <= '0;
		end else if (state_q == ST_DONE) begin
			for (int k = 0; k < 6; k++)
				acc_q[k] <= '0;
			smpIdx_q <= '0;
		end else if (take) begin
			for (int k = 0; k < 6; k++)
				acc_q[k] <= acc_q[k] + contrib[k];
			smpIdx_q <= smpIdx_q + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossing detection and period bound snapshots
	logic signed [SAMPLE_W-1:0] syncVal, centreUsed, syncCentre_q;
	logic                       above, prevAbove_q, havePrev_q;
	logic [1:0]                 edgeHit, crossCnt_q [2];
	acc_t                       snapF_q [2][6];
	acc_t                       snapL_q [2][6];
	logic [CNT_W-1:0]           idxF_q [2];
	logic [CNT_W-1:0]           idxL_q [2];

	always_comb begin
		case (pmc_sync_t'(ctrl_q[`PMC_F_SYNC]))
			SYNC_U:   syncVal = samp[0];
			SYNC_I:   syncVal = samp[1];
			default:  syncVal = sExt ? SAMPLE_W'(1) : -SAMPLE_W'(1);
		endcase
		centreUsed = (ctrl_q[`PMC_F_SYNC] >= 2'(SYNC_EXT)) ? '0 : syncCentre_q;
		above      = (syncVal >= centreUsed);
		edgeHit[0] = havePrev_q && !prevAbove_q && above;
		edgeHit[1] = havePrev_q && prevAbove_q && !above;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prevAbove_q <= 1'b0;
			havePrev_q  <= 1'b0;
			for (int s = 0; s < 2; s++) begin
				crossCnt_q[s] <= '0;
				idxF_q[s]     <= '0;
				idxL_q[s]     <= '0;
				for (int k = 0; k < 6; k++) begin
					snapF_q[s][k] <= '0;
					snapL_q[s][k] <= '0;
				end
			end
		end else if (state_q == ST_DONE) begin
			for (int s = 0; s < 2; s++)
				crossCnt_q[s] <= '0;
		end else if (take) begin
			prevAbove_q <= above;
			havePrev_q  <= 1'b1;
			for (int s = 0; s < 2; s++) begin
				if (edgeHit[s]) begin
					if (crossCnt_q[s] == 2'h0) begin
						idxF_q[s]  <= smpIdx_q;
						snapF_q[s] <= acc_q;
					end
					idxL_q[s]  <= smpIdx_q;
					snapL_q[s] <= acc_q;
					if (crossCnt_q[s] != 2'h2)
						crossCnt_q[s] <= crossCnt_q[s] + 2'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Peaks over the whole interval and window flags
	logic signed [SAMPLE_W-1:0] pkMax_q [2];
	logic signed [SAMPLE_W-1:0] pkMin_q [2];
	logic signed [SAMPLE_W-1:0] repMax_q [2];
	logic signed [SAMPLE_W-1:0] repMin_q [2];
	logic                       harm_q, fft_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 2; c++) begin
				pkMax_q[c] <= '0;
				pkMin_q[c] <= '0;
			end
		end else if (take) begin
			for (int c = 0; c < 2; c++) begin
				if (smpIdx_q == '0 || samp[c] > pkMax_q[c])
					pkMax_q[c] <= samp[c];
				if (smpIdx_q == '0 || samp[c] < pkMin_q[c])
					pkMin_q[c] <= samp[c];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			harm_q <= 1'b0;
			fft_q  <= 1'b0;
		end else begin
			harm_q <= take && (smpIdx_q < CNT_W'(HARM_PTS));
			fft_q  <= take && (smpIdx_q < (ctrl_q[`PMC_B_FFTLONG] ?
				CNT_W'(FFT_LONG) : CNT_W'(FFT_SHORT)));
		end
	end
	assign harmWindow = harm_q;
	assign fftWindow  = fft_q;

	////////////////////////////////////////////////////////////////////////////////
	// Period choice and per-period evaluation sequence
	logic             whole_q, useFall_q, ch_q, issued_q, unitStart, unitDone, unitSqrt;
	logic [CNT_W-1:0] periodN_q, lenR, lenF;
	logic [ACC_W-1:0] unitA, unitB, unitRes;
	logic [1:0]       chMode;
	acc_t             selSum;
	logic signed [31:0] val_q, scaled, filtered, absRes;
	logic signed [31:0] filt_q [2];
	logic signed [31:0] result_q [2];
	logic [31:0]      crest_q [2];
	logic [SAMPLE_W:0] pkAbs;
	logic [31:0]      count_q;
	logic             valid_q;
	logic signed [47:0] prod;

	assign lenR   = idxL_q[0] - idxF_q[0];
	assign lenF   = idxL_q[1] - idxF_q[1];
	assign chMode = ch_q ? ctrl_q[`PMC_F_IMODE] : ctrl_q[`PMC_F_VMODE];

	always_comb begin
		int k;
		k      = (ch_q ? 3 : 0) + accSlot(chMode);
		selSum = whole_q ? acc_q[k]
			: snapL_q[useFall_q][k] - snapF_q[useFall_q][k];
		pkAbs  = (-(SAMPLE_W+1)'(pkMin_q[ch_q]) > (SAMPLE_W+1)'(pkMax_q[ch_q]))
			? -(SAMPLE_W+1)'(pkMin_q[ch_q]) : (SAMPLE_W+1)'(pkMax_q[ch_q]);
		prod   = val_q * $signed({1'b0, `PMC_CAL_COEF});
		scaled = (pmc_mode_t'(chMode) == MODE_MN)
			? 32'(prod >>> `PMC_CAL_SHIFT) : val_q;
		filtered = ctrl_q[`PMC_B_FILT]
			? filt_q[ch_q] + ((scaled - filt_q[ch_q]) >>> `PMC_FILT_SHIFT) : scaled;
		absRes = result_q[ch_q][31] ? -result_q[ch_q] : result_q[ch_q];
		unitSqrt = (state_q == ST_SQRT);
		case (state_q)
			ST_MEAN: begin
				unitA = selSum[ACC_W-1] ? ACC_W'(-selSum) : ACC_W'(selSum);
				unitB = ACC_W'(periodN_q);
			end
			ST_SQRT: begin
				unitA = ACC_W'(unsigned'(val_q));
				unitB = '0;
			end
			default: begin
				unitA = ACC_W'(pkAbs) << `PMC_CREST_FRAC;
				unitB = ACC_W'(unsigned'(absRes));
			end
		endcase
		unitStart = !issued_q && (state_q == ST_MEAN || state_q == ST_SQRT
			|| state_q == ST_CREST);
	end

	pmc_iter_unit #(.W(ACC_W)) u_unit (
		.clk    (clk),
		.rst_n  (rst_n),
		.start  (unitStart),
		.opSqrt (unitSqrt),
		.opA    (unitA),
		.opB    (unitB),
		.done   (unitDone),
		.result (unitRes)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			whole_q <= 1'b1; useFall_q <= 1'b0; ch_q <= 1'b0; issued_q <= 1'b0;
			periodN_q <= '0; val_q <= '0; count_q <= '0; valid_q <= 1'b0;
			syncCentre_q <= '0;
			for (int c = 0; c < 2; c++) begin
				filt_q[c] <= '0; result_q[c] <= '0; crest_q[c] <= '0;
				repMax_q[c] <= '0; repMin_q[c] <= '0;
			end
		end else begin
			valid_q <= 1'b0;
			if (unitStart)
				issued_q <= 1'b1;
			else if (unitDone)
				issued_q <= 1'b0;
			case (state_q)
				ST_RUN: if (lastSample) state_q <= ST_PICK;
				ST_PICK: begin
					if (!zeroCrossRate(ctrl_q[`PMC_F_RATE])
						|| (crossCnt_q[0] < 2'h2 && crossCnt_q[1] < 2'h2)) begin
						whole_q   <= 1'b1;
						periodN_q <= smpIdx_q;
					end else if (crossCnt_q[1] == 2'h2
						&& (crossCnt_q[0] < 2'h2 || lenF > lenR)) begin
						whole_q <= 1'b0; useFall_q <= 1'b1; periodN_q <= lenF;
					end else begin
						whole_q <= 1'b0; useFall_q <= 1'b0; periodN_q <= lenR;
					end
					for (int c = 0; c < 2; c++) begin
						repMax_q[c] <= pkMax_q[c];
						repMin_q[c] <= pkMin_q[c];
					end
					if (ctrl_q[`PMC_F_SYNC] == 2'(SYNC_U))
						syncCentre_q <= SAMPLE_W'(((SAMPLE_W+1)'(pkMax_q[0])
							+ (SAMPLE_W+1)'(pkMin_q[0])) >>> 1);
					else if (ctrl_q[`PMC_F_SYNC] == 2'(SYNC_I))
						syncCentre_q <= SAMPLE_W'(((SAMPLE_W+1)'(pkMax_q[1])
							+ (SAMPLE_W+1)'(pkMin_q[1])) >>> 1);
					ch_q    <= 1'b0;
					state_q <= ST_MEAN;
				end
				ST_MEAN: if (unitDone) begin
					val_q   <= selSum[ACC_W-1] ? -$signed(unitRes[31:0])
						: $signed(unitRes[31:0]);
					state_q <= (pmc_mode_t'(chMode) == MODE_RMS) ? ST_SQRT : ST_SCALE;
				end
				ST_SQRT: if (unitDone) begin
					val_q   <= $signed(unitRes[31:0]);
					state_q <= ST_SCALE;
				end
				ST_SCALE: begin
					filt_q[ch_q]   <= filtered;
					result_q[ch_q] <= filtered;
					state_q        <= ST_CREST;
				end
				ST_CREST: if (unitDone) begin
					crest_q[ch_q] <= unitRes[31:0];
					ch_q          <= 1'b1;
					state_q       <= ch_q ? ST_DONE : ST_MEAN;
				end
				ST_DONE: begin
					count_q <= count_q + 32'h1;
					valid_q <= 1'b1;
					state_q <= ST_RUN;
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end
	assign resultValid = valid_q;

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM register slave
	logic        waitReq_q;
	logic [31:0] rdData_q, rdMux;

	always_comb begin
		case (avs_address)
			`PMC_REG_CTRL:    rdMux = 32'(ctrl_q);
			`PMC_REG_STATUS:  rdMux = {28'h0, (state_q != ST_RUN), fft_q, useFall_q, whole_q};
			`PMC_REG_U_VALUE: rdMux = result_q[0];
			`PMC_REG_I_VALUE: rdMux = result_q[1];
			`PMC_REG_U_MAXPK: rdMux = 32'(repMax_q[0]);
			`PMC_REG_U_MINPK: rdMux = 32'(repMin_q[0]);
			`PMC_REG_I_MAXPK: rdMux = 32'(repMax_q[1]);
			`PMC_REG_I_MINPK: rdMux = 32'(repMin_q[1]);
			`PMC_REG_U_CREST: rdMux = crest_q[0];
			`PMC_REG_I_CREST: rdMux = crest_q[1];
			`PMC_REG_PERIOD:  rdMux = 32'(periodN_q);
			`PMC_REG_COUNT:   rdMux = count_q;
			default:          rdMux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitReq_q <= 1'b1;
			rdData_q  <= 32'h0;
		end else if (!waitReq_q) begin
			waitReq_q <= 1'b1;
		end else if (avs_read || avs_write) begin
			waitReq_q <= 1'b0;
			rdData_q  <= avs_read ? rdMux : 32'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctrl_q <= `PMC_CTRL_RESET;
		else if (avs_write && !waitReq_q && avs_address == `PMC_REG_CTRL)
			ctrl_q <= avs_writedata[`PMC_CTRL_W-1:0];
	end
	assign avs_readdata    = rdData_q;
	assign avs_waitrequest = waitReq_q;
endmodule : pmc_period_compute

// ===== verilog/pmc_pkg.sv
// Types shared by the measurement period core
package pmc_pkg;
	typedef enum logic [1:0] {MODE_RMS, MODE_MN, MODE_DC, MODE_RMN} pmc_mode_t;
	typedef enum logic [1:0] {SYNC_U, SYNC_I, SYNC_EXT, SYNC_RSVD} pmc_sync_t;
	typedef enum logic [3:0] {
		RATE_50MS, RATE_100MS, RATE_250MS, RATE_500MS, RATE_1S,
		RATE_2S, RATE_5S, RATE_10S, RATE_20S
	} pmc_rate_t;
	typedef enum logic [2:0] {
		ST_RUN, ST_PICK, ST_MEAN, ST_SQRT, ST_SCALE, ST_CREST, ST_DONE
	} pmc_state_t;
endpackage : pmc_pkg

// ===== verilog/pmc_skid_buf.sv
// Small sample buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_skid_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `PMC_FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("pmc_skid_buf needs DEPTH >= 2 and WIDTH >= 1");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_q, rdPtr_q;
	logic [PTR_W:0]   cnt_q, cnt_d;
	logic             inReady_q, push, pop;

	function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
		nextPtr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction : nextPtr

	assign push     = inValid && inReady_q;
	assign outValid = (cnt_q != '0);
	assign pop      = outValid && outReady;
	assign outData  = mem[rdPtr_q];
	assign inReady  = inReady_q;

	always_comb begin
		cnt_d = cnt_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q   <= '0;
			rdPtr_q   <= '0;
			cnt_q     <= '0;
			inReady_q <= 1'b0;
		end else begin
			if (push)
				wrPtr_q <= nextPtr(wrPtr_q);
			if (pop)
				rdPtr_q <= nextPtr(rdPtr_q);
			cnt_q     <= cnt_d;
			inReady_q <= (cnt_d != (PTR_W+1)'(DEPTH));
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem[wrPtr_q] <= inData;
	end
endmodule : pmc_skid_buf
